// file: spi_port_host.sv
module spi_port_host
  import spi_unit_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq,
  spi_link_if.host         link
);

  logic [31:0]    cfg_q;
  logic [7:0]     tx_q;
  logic [7:0]     rxbuf_q;
  logic [1:0]     ev_q;
  logic [1:0]     mask_q;
  logic [4:0]     aw_q;
  logic [31:0]    w_q;
  logic [3:0]     ws_q;
  logic           aw_full_q;
  logic           w_full_q;
  logic [7:0]     sh_q;
  logic [7:0]     rx_q;
  logic [2:0]     bits_q;
  logic [1:0]     sclk_s;
  logic [1:0]     ss_s;
  logic [1:0]     din_s;
  logic           sclk_p;
  logic           ss_p;
  xfer_state_type m_state_q;
  logic [7:0]     hcnt_q;
  logic [4:0]     halves_q;
  logic           sclk_q;
  logic           sclk_oe_q;
  logic           ss_n_q;
  logic           ss_oe_q;
  logic           dout_q;
  logic           dout_oe_q;

  logic       enabled;
  logic       is_master;
  logic       phase;
  logic       do_write;
  logic       tick;
  logic       m_start;
  logic       s_act;
  logic       s_start;
  logic       lead;
  logic       trail;
  logic       shift_ev;
  logic       samp_ev;
  logic       complete;
  logic [7:0] load_data;
  logic [7:0] rx_byte;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [4:0] a);
    return a == CFG_ADDR || a == TX_ADDR || a == RX_ADDR || a == STATUS_ADDR
           || a == EVENT_ADDR || a == MASK_ADDR;
  endfunction : mapped

  assign enabled  = cfg_q[HOST_EN_BIT];
  assign is_master = cfg_q[HOST_MASTER_BIT];
  assign phase    = cfg_q[HOST_PHASE_BIT];
  assign do_write = aw_full_q && w_full_q && !bvalid;

  assign tick    = m_state_q == XFER_SHIFT && hcnt_q == cfg_q[HALF_LSB +: 8];
  assign m_start = do_write && aw_q == TX_ADDR && ws_q[0] && enabled && is_master
                   && m_state_q == XFER_IDLE;
  assign s_act   = enabled && !is_master && !ss_s[1];
  assign s_start = s_act && ss_p;
  assign lead  = is_master ? (tick && !sclk_q && halves_q != LAST_HALF)
                           : (s_act && sclk_s[1] && !sclk_p);
  assign trail = is_master ? (tick && sclk_q) : (s_act && !sclk_s[1] && sclk_p);
  assign shift_ev  = phase ? lead : trail;
  assign samp_ev   = phase ? trail : lead;
  assign complete  = samp_ev && bits_q == LAST_BIT;
  assign rx_byte   = {rx_q[6:0], din_s[1]};
  assign load_data = m_start ? w_q[7:0] : tx_q;

  assign link.host_sclk_o  = sclk_q;
  assign link.host_sclk_oe = sclk_oe_q;
  assign link.host_ss_n_o  = ss_n_q;
  assign link.host_ss_oe   = ss_oe_q;
  assign link.host_dout    = dout_q;
  assign link.host_dout_oe = dout_oe_q;

  // write channels are taken independently, the response follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_q      <= 5'h00;
      w_q       <= 32'h0000_0000;
      ws_q      <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else if (ce) begin
      awready <= !aw_full_q && !(awvalid && awready);
      wready  <= !w_full_q && !(wvalid && wready);
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_q      <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_q      <= wdata;
        ws_q     <= wstrb;
      end
      if (do_write) begin
        bvalid    <= 1'b1;
        bresp     <= mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        awready   <= 1'b0;
        wready    <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid  <= 1'b1;
        arready <= 1'b0;
        rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        unique case (araddr)
          CFG_ADDR:    rdata <= cfg_q;
          TX_ADDR:     rdata <= {24'h00_0000, tx_q};
          RX_ADDR:     rdata <= {24'h00_0000, rxbuf_q};
          STATUS_ADDR: rdata <= {31'h0000_0000, m_state_q == XFER_SHIFT};
          EVENT_ADDR:  rdata <= {30'h0000_0000, ev_q};
          MASK_ADDR:   rdata <= {30'h0000_0000, mask_q};
          default:     rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // events are sticky, write one clears, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q   <= CFG_RESET;
      tx_q    <= 8'h00;
      mask_q  <= 2'h0;
      ev_q    <= 2'h0;
      rxbuf_q <= 8'h00;
      irq     <= 1'b0;
    end else if (ce) begin
      if (do_write && aw_q == CFG_ADDR) begin
        cfg_q <= merge(cfg_q, w_q, ws_q);
      end
      if (do_write && aw_q == TX_ADDR && ws_q[0]) begin
        tx_q <= w_q[7:0];
      end
      if (do_write && aw_q == MASK_ADDR && ws_q[0]) begin
        mask_q <= w_q[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (do_write && aw_q == EVENT_ADDR && ws_q[0] && w_q[i]) begin
          ev_q[i] <= 1'b0;
        end
      end
      if (complete) begin
        rxbuf_q           <= rx_byte;
        ev_q[EV_DONE_BIT] <= 1'b1;
        if (ev_q[EV_DONE_BIT]) begin
          ev_q[EV_OVR_BIT] <= 1'b1;
        end
      end
      irq <= |(ev_q & mask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_s <= 2'h0;
      ss_s   <= 2'h3;
      din_s  <= 2'h0;
      sclk_p <= 1'b0;
      ss_p   <= 1'b1;
    end else if (ce) begin
      sclk_s <= {sclk_s[0], link.port3_bit4_pin};
      ss_s   <= {ss_s[0], link.port3_bit5_pin_n};
      din_s  <= {din_s[0], link.port2_bit7_pin};
      sclk_p <= sclk_s[1];
      ss_p   <= ss_s[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_state_q <= XFER_IDLE;
      hcnt_q    <= 8'h00;
      halves_q  <= 5'h00;
      sclk_q    <= 1'b0;
    end else if (ce) begin
      hcnt_q <= (m_state_q != XFER_SHIFT || tick) ? 8'h00 : hcnt_q + 8'h01;
      unique case (m_state_q)
        XFER_IDLE: begin
          sclk_q   <= 1'b0;
          halves_q <= 5'h00;
          if (m_start) begin
            m_state_q <= XFER_SHIFT;
          end
        end
        XFER_SHIFT: begin
          if (!enabled || !is_master || (tick && halves_q == LAST_HALF)) begin
            m_state_q <= XFER_IDLE;
            sclk_q    <= 1'b0;
          end else if (tick) begin
            sclk_q   <= !sclk_q;
            halves_q <= halves_q + 5'h01;
          end
        end
        default: m_state_q <= XFER_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q      <= 8'h00;
      rx_q      <= 8'h00;
      bits_q    <= 3'h0;
      dout_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
      ss_n_q    <= 1'b1;
      ss_oe_q   <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (ce) begin
      if (m_start || s_start) begin
        bits_q <= 3'h0;
        sh_q   <= phase ? load_data : {load_data[6:0], 1'b0};
        if (!phase) begin
          dout_q <= load_data[7];
        end
      end else begin
        if (shift_ev) begin
          dout_q <= sh_q[7];
          sh_q   <= {sh_q[6:0], 1'b0};
        end
        if (samp_ev) begin
          rx_q   <= rx_byte;
          bits_q <= bits_q + 3'h1;
        end
      end
      sclk_oe_q <= enabled && is_master;
      ss_oe_q   <= enabled && is_master;
      ss_n_q    <= m_state_q != XFER_SHIFT;
      dout_oe_q <= enabled && (is_master || s_act);
    end
  end

endmodule : spi_port_host

// file: spi_unit_pkg.sv
package spi_unit_pkg;

  // device register bank
  localparam logic [7:0] BUFFER_OFFSET  = 8'h01;
  localparam logic [7:0] CTRL_OFFSET    = 8'h02;
  localparam logic [7:0] COMPARE_OFFSET = 8'h03;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  localparam int ROLE_BIT       = 7;
  localparam int SOURCE_BIT     = 6;
  localparam int PHASE_BIT      = 5;
  localparam int RX_AVAIL_BIT   = 4;
  localparam int COMPARE_EN_BIT = 3;
  localparam int DOUT_PORT_BIT  = 2;
  localparam int OVERRUN_BIT    = 1;
  localparam int DIVIDE_LSB     = 1;
  localparam int ENABLE_BIT     = 0;

  // one character is eight bits; a master transfer is sixteen half periods plus a tail
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [4:0] LAST_HALF = 5'h10;

  // controller register map, byte addresses
  localparam logic [4:0] CFG_ADDR    = 5'h00;
  localparam logic [4:0] TX_ADDR     = 5'h04;
  localparam logic [4:0] RX_ADDR     = 5'h08;
  localparam logic [4:0] STATUS_ADDR = 5'h0C;
  localparam logic [4:0] EVENT_ADDR  = 5'h10;
  localparam logic [4:0] MASK_ADDR   = 5'h14;

  localparam logic [31:0] CFG_RESET = 32'h0000_1000;
  localparam int HOST_EN_BIT     = 0;
  localparam int HOST_MASTER_BIT = 1;
  localparam int HOST_PHASE_BIT  = 2;
  localparam int HALF_LSB        = 8;
  localparam int EV_DONE_BIT     = 0;
  localparam int EV_OVR_BIT      = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b01,
    XFER_SHIFT = 2'b10
  } xfer_state_type;

  // aclk cycles per serial clock half period from the internal source
  function automatic logic [8:0] half_cycles(input int xtal, input logic [1:0] div,
                                             input logic low_noise);
    logic [8:0] base;
    base = low_noise ? (9'h001 << div) : (9'h002 << div);
    return 9'(xtal * int'(base));
  endfunction : half_cycles

endpackage : spi_unit_pkg

// file: spi_link_if.sv
interface spi_link_if;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic host_sclk_o;
  logic host_sclk_oe;
  logic dev_ss_n_o;
  logic dev_ss_oe;
  logic host_ss_n_o;
  logic host_ss_oe;
  logic dev_dout;
  logic dev_dout_oe;
  logic host_dout;
  logic host_dout_oe;
  logic port3_bit4_pin;
  logic port3_bit5_pin_n;
  logic port2_bit7_pin;
  logic port2_bit0_pin;

  // clock and data idle low, slave select idles high
  assign port3_bit4_pin   = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b0);
  assign port3_bit5_pin_n = dev_ss_oe ? dev_ss_n_o : (host_ss_oe ? host_ss_n_o : 1'b1);
  assign port2_bit7_pin   = dev_dout_oe ? dev_dout : 1'b0;
  assign port2_bit0_pin   = host_dout_oe ? host_dout : 1'b0;

  modport device (
    output dev_sclk_o, dev_sclk_oe, dev_ss_n_o, dev_ss_oe, dev_dout, dev_dout_oe,
    input  port3_bit4_pin, port3_bit5_pin_n, port2_bit0_pin
  );
  modport host (
    output host_sclk_o, host_sclk_oe, host_ss_n_o, host_ss_oe, host_dout, host_dout_oe,
    input  port3_bit4_pin, port3_bit5_pin_n, port2_bit7_pin
  );
endinterface : spi_link_if

// file: spi_port_device.sv
// Notes on behaviour
// - only the master drives the serial clock
// - default: change data falling, sample rising
// - characters shift most significant bit first
// - control at 02, plus buffer and compare
// - control bit 7 chooses master or slave
// - master bit 6: timer or internal clock
// - phase bit 5 set sends rising, latches falling
// - receive-full flag bit 4 raises interrupt
// - compare enable ignored in master mode
// - divide field gives crystal/4, /8, /16, /32
// - base clock half crystal, full when low-noise
// - bit 0 enables unit, routes port pins
// - slave acts only while select held low
// - slave ignores clock source bit
// - slave compare match while asleep wakes
// - slave bit 2 hands data-out to port
// - slave bit 1 overrun, write one clears
module spi_port_device
  import spi_unit_pkg::*;
#(
  parameter int XTAL_CYCLES = 8
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       low_noise_mode,
  input  wire logic       timer0_output,
  input  wire logic       asleep,
  output logic            serial_interrupt_request,
  output logic            stop_recover,
  spi_link_if.device      link
);

  if (XTAL_CYCLES < 4 || XTAL_CYCLES > 16) begin : g_bad_xtal
    $error("XTAL_CYCLES must lie in 4..16");
  end
  logic [7:0]     ctrl_q;
  logic [7:0]     tx_q;
  logic [7:0]     cmp_q;
  logic [7:0]     rxbuf_q;
  logic [7:0]     sh_q;
  logic [7:0]     rx_q;
  logic           avail_q;
  logic           ovr_q;
  logic [2:0]     bits_q;
  logic [1:0]     sclk_s;
  logic [1:0]     ss_s;
  logic [1:0]     din_s;
  logic [1:0]     tmr_s;
  logic           sclk_p;
  logic           ss_p;
  logic           tmr_p;
  xfer_state_type m_state_q;
  logic [8:0]     hcnt_q;
  logic [4:0]     halves_q;
  logic           sclk_q;
  logic           sclk_oe_q;
  logic           ss_n_q;
  logic           ss_oe_q;
  logic           dout_q;
  logic           dout_oe_q;
  logic           armed_q;

  logic       enabled;
  logic       is_master;
  logic       phase;
  logic       wr_ctrl;
  logic       wr_buf;
  logic       wr_cmp;
  logic [8:0] limit;
  logic       base_tick;
  logic       tick;
  logic       m_start;
  logic       s_act;
  logic       s_start;
  logic       lead;
  logic       trail;
  logic       shift_ev;
  logic       samp_ev;
  logic       complete;
  logic [7:0] load_data;
  logic [7:0] rx_byte;
  logic [7:0] ctrl_view;

  assign enabled   = ctrl_q[ENABLE_BIT];
  assign is_master = ctrl_q[ROLE_BIT];
  assign phase     = ctrl_q[PHASE_BIT];
  assign wr_ctrl   = reg_wr && reg_addr == CTRL_OFFSET;
  assign wr_buf    = reg_wr && reg_addr == BUFFER_OFFSET;
  assign wr_cmp    = reg_wr && reg_addr == COMPARE_OFFSET;
  // half period: base clock per low-noise bit, scaled by the divide field
  assign limit = half_cycles(XTAL_CYCLES, ctrl_q[DIVIDE_LSB +: 2], low_noise_mode)
                 - 9'h001;
  // source bit read only in master mode
  assign base_tick = ctrl_q[SOURCE_BIT] ? (tmr_s[1] && !tmr_p) : (hcnt_q == limit);
  // timer source: first edge only arms, so select leads by at least a half period
  assign tick      = m_state_q == XFER_SHIFT && base_tick && (armed_q || !ctrl_q[SOURCE_BIT]);
  assign m_start   = wr_buf && enabled && is_master && m_state_q == XFER_IDLE;
  assign s_act   = enabled && !is_master && !ss_s[1];
  assign s_start = s_act && ss_p;
  assign lead  = is_master ? (tick && !sclk_q && halves_q != LAST_HALF)
                           : (s_act && sclk_s[1] && !sclk_p);
  assign trail = is_master ? (tick && sclk_q) : (s_act && !sclk_s[1] && sclk_p);
  assign shift_ev  = phase ? lead : trail;
  assign samp_ev   = phase ? trail : lead;
  assign complete  = samp_ev && bits_q == LAST_BIT;
  assign rx_byte   = {rx_q[6:0], din_s[1]};
  assign load_data = m_start ? reg_wdata : tx_q;
  assign ctrl_view = {ctrl_q[7:5], avail_q, ctrl_q[3:2],
                      is_master ? ctrl_q[OVERRUN_BIT] : ovr_q, ctrl_q[0]};
  assign link.dev_sclk_o  = sclk_q;
  assign link.dev_sclk_oe = sclk_oe_q;
  assign link.dev_ss_n_o  = ss_n_q;
  assign link.dev_ss_oe   = ss_oe_q;
  assign link.dev_dout    = dout_q;
  assign link.dev_dout_oe = dout_oe_q;
  // pins are sampled through two flip-flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_s <= 2'h0;
      ss_s   <= 2'h3;
      din_s  <= 2'h0;
      tmr_s  <= 2'h0;
      sclk_p <= 1'b0;
      ss_p   <= 1'b1;
      tmr_p  <= 1'b0;
    end else if (ce) begin
      sclk_s <= {sclk_s[0], link.port3_bit4_pin};
      ss_s   <= {ss_s[0], link.port3_bit5_pin_n};
      din_s  <= {din_s[0], link.port2_bit0_pin};
      tmr_s  <= {tmr_s[0], timer0_output};
      sclk_p <= sclk_s[1];
      ss_p   <= ss_s[1];
      tmr_p  <= tmr_s[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      tx_q   <= 8'h00;
      cmp_q  <= 8'h00;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (wr_buf) begin
        tx_q <= reg_wdata;
      end
      if (wr_cmp) begin
        cmp_q <= reg_wdata;
      end
    end
  end
  // hardware set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avail_q <= 1'b0;
      ovr_q   <= 1'b0;
      rxbuf_q <= 8'h00;
    end else if (ce) begin
      if (complete) begin
        rxbuf_q <= rx_byte;
        avail_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[RX_AVAIL_BIT]) begin
        avail_q <= 1'b0;
      end
      if (complete && avail_q) begin
        ovr_q <= 1'b1;
      end else if (wr_ctrl && !is_master && reg_wdata[OVERRUN_BIT]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_interrupt_request <= 1'b0;
      stop_recover             <= 1'b0;
      reg_rdata                <= 8'h00;
    end else if (ce) begin
      serial_interrupt_request <= complete;
      stop_recover <= complete && !is_master && ctrl_q[COMPARE_EN_BIT] && asleep
                      && rx_byte == cmp_q;
      unique case (reg_addr)
        CTRL_OFFSET:    reg_rdata <= ctrl_view;
        BUFFER_OFFSET:  reg_rdata <= rxbuf_q;
        COMPARE_OFFSET: reg_rdata <= cmp_q;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end
  // master clock generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_state_q <= XFER_IDLE;
      hcnt_q    <= 9'h000;
      halves_q  <= 5'h00;
      sclk_q    <= 1'b0;
      armed_q   <= 1'b0;
    end else if (ce) begin
      hcnt_q <= (m_state_q != XFER_SHIFT || hcnt_q == limit) ? 9'h000 : hcnt_q + 9'h001;
      armed_q <= m_state_q == XFER_SHIFT && (armed_q || base_tick);
      unique case (m_state_q)
        XFER_IDLE: begin
          sclk_q   <= 1'b0;
          halves_q <= 5'h00;
          if (m_start) begin
            m_state_q <= XFER_SHIFT;
          end
        end
        XFER_SHIFT: begin
          if (!enabled || !is_master || (tick && halves_q == LAST_HALF)) begin
            m_state_q <= XFER_IDLE;
            sclk_q    <= 1'b0;
          end else if (tick) begin
            sclk_q   <= !sclk_q;
            halves_q <= halves_q + 5'h01;
          end
        end
        default: m_state_q <= XFER_IDLE;
      endcase
    end
  end
  // shift engine shared by both roles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q   <= 8'h00;
      rx_q   <= 8'h00;
      bits_q <= 3'h0;
      dout_q <= 1'b0;
    end else if (ce) begin
      if (m_start || s_start) begin
        bits_q <= 3'h0;
        sh_q   <= phase ? load_data : {load_data[6:0], 1'b0};
        if (!phase) begin
          dout_q <= load_data[7];
        end
      end else begin
        if (shift_ev) begin
          dout_q <= sh_q[7];
          sh_q   <= {sh_q[6:0], 1'b0};
        end
        if (samp_ev) begin
          rx_q   <= rx_byte;
          bits_q <= bits_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_oe_q <= 1'b0;
      ss_n_q    <= 1'b1;
      ss_oe_q   <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (ce) begin
      sclk_oe_q <= enabled && is_master;
      ss_oe_q   <= enabled && is_master;
      ss_n_q    <= m_state_q != XFER_SHIFT;
      dout_oe_q <= enabled && (is_master || (s_act && !ctrl_q[DOUT_PORT_BIT]));
    end
  end

endmodule : spi_port_device

// file: spi_link_monitor.sv
module spi_link_monitor (
  input logic aclk,
  input logic aresetn,
  input logic dev_sclk_oe,
  input logic host_sclk_oe,
  input logic dev_ss_oe,
  input logic host_ss_oe,
  input logic port3_bit4_pin,
  input logic port3_bit5_pin_n
);
  logic [3:0] rise_q;
  logic       sclk_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_select;
    $fell(port3_bit5_pin_n);
  endsequence
  sequence s_release;
    $rose(port3_bit5_pin_n);
  endsequence
  // rising clock edges seen inside the current frame
  always_ff @(posedge aclk) begin
    sclk_q <= port3_bit4_pin;
    if (!aresetn || port3_bit5_pin_n) begin
      rise_q <= 4'h0;
    end else if (port3_bit4_pin && !sclk_q) begin
      rise_q <= rise_q + 4'h1;
    end
  end
  a_one_clock_drv: assert property (!(dev_sclk_oe && host_sclk_oe))
    else $error("two drivers on serial clock");
  a_one_select_drv: assert property (!(dev_ss_oe && host_ss_oe))
    else $error("two drivers on slave select");
  a_clock_in_frame: assert property ($changed(port3_bit4_pin) |-> !port3_bit5_pin_n)
    else $error("serial clock moved outside a frame");
  a_lead_gap: assert property (s_select |-> !port3_bit4_pin [*6])
    else $error("clock edge too soon after select");
  a_half_min: assert property ($changed(port3_bit4_pin) |=> $stable(port3_bit4_pin) [*5])
    else $error("serial half period too short");
  a_frame_end: assert property (s_select |-> ##[1:1000] s_release)
    else $error("frame never ended");
  a_idle_low_end: assert property (s_release |-> !port3_bit4_pin)
    else $error("clock not idle low at frame end");
  a_eight_edges: assert property (s_release |-> rise_q == 4'h8)
    else $error("frame did not hold eight clock edges");
endmodule : spi_link_monitor

// file: tb.sv
module tb
  import spi_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = '0, aresetn = '0, ce = 1'h1, reg_wr = '0, low_noise_mode = '0;
  logic        timer0_output = '0, asleep = '0, ph = '0, sk_q;
  logic [7:0]  reg_addr = '0, reg_wdata = '0, reg_rdata, cap;
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, got;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic        serial_interrupt_request, stop_recover;
  int          n_errors = 0, checks = 0, n_rx = 0, n_wake = 0, half;
  spi_link_if link ();
  spi_port_device #(.XTAL_CYCLES(4)) i_spi_port_device (.*);
  spi_port_host i_spi_port_host (.*);
  spi_link_monitor i_spi_link_monitor (.aclk(aclk), .aresetn(aresetn),
    .dev_sclk_oe(link.dev_sclk_oe), .host_sclk_oe(link.host_sclk_oe),
    .dev_ss_oe(link.dev_ss_oe), .host_ss_oe(link.host_ss_oe),
    .port3_bit4_pin(link.port3_bit4_pin), .port3_bit5_pin_n(link.port3_bit5_pin_n));
  always #5 aclk = !aclk;
  always begin
    repeat (10) @(posedge aclk);
    timer0_output <= !timer0_output;
  end
  // host data out captured at its sampling edge
  always @(posedge aclk) begin
    sk_q <= link.port3_bit4_pin;
    if (link.port3_bit4_pin !== sk_q && link.port3_bit4_pin != ph && !link.port3_bit5_pin_n)
      cap <= {cap[6:0], link.port2_bit0_pin};
    if (serial_interrupt_request) n_rx++;
    if (stop_recover) n_wake++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run();
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge aclk);
    reg_wr <= 1'h0;
  endtask : dev_wr
  task automatic dev_rd(input logic [7:0] a);
    @(posedge aclk);
    reg_addr <= a;
    repeat (2) @(posedge aclk);
    got = 32'(reg_rdata);
  endtask : dev_rd
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", 32'(RESP_OKAY), 32'(bresp));
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    got = rdata;
    chk("rresp", 32'(er), 32'(rresp));
  endtask : axi_rd
  // waits out one frame and measures its second half period
  task automatic frame();
    logic s;
    while (link.port3_bit5_pin_n) @(posedge aclk);
    s = link.port3_bit4_pin;
    while (link.port3_bit4_pin === s) @(posedge aclk);
    s = link.port3_bit4_pin;
    half = 0;
    while (link.port3_bit4_pin === s) begin
      @(posedge aclk);
      half++;
    end
    while (!link.port3_bit5_pin_n) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask : frame
  task automatic t_regs();
    axi_rd(CFG_ADDR, RESP_OKAY);
    chk("cfg", CFG_RESET, got);
    axi_rd(5'h18, RESP_SLVERR);
    dev_rd(CTRL_OFFSET);
    chk("ctrl", 32'(CTRL_RESET), got);
    dev_rd(8'h07);
    chk("unmapped", 32'h0000_0000, got);
  endtask : t_regs
  task automatic t_host_master();
    for (int p = 0; p < 2; p++) begin
      ph = p[0];
      dev_wr(CTRL_OFFSET, {2'h0, ph, 5'h01});
      dev_wr(BUFFER_OFFSET, 8'h3C);
      axi_wr(MASK_ADDR, 32'h0000_0001);
      axi_wr(CFG_ADDR, {16'h0000, 8'h07, 5'h00, ph, 2'h3});
      axi_wr(TX_ADDR, 32'h0000_00A5);
      frame();
      chk("wire", 32'h0000_00A5, 32'(cap));
      dev_rd(BUFFER_OFFSET);
      chk("dev rx", 32'h0000_00A5, got);
      axi_rd(RX_ADDR, RESP_OKAY);
      chk("host rx", 32'h0000_003C, got);
      chk("dev ints", 32'(2 * p + 1), 32'(n_rx));
      chk("irq", 32'h0000_0001, 32'(irq));
      axi_wr(EVENT_ADDR, 32'h0000_0003);
      axi_wr(MASK_ADDR, 32'h0000_0000);
      axi_wr(TX_ADDR, 32'h0000_005A);
      frame();
      chk("irq masked", 32'h0000_0000, 32'(irq));
      dev_rd(CTRL_OFFSET);
      chk("overrun", 32'({2'h0, ph, 5'h13}), got);
      dev_wr(CTRL_OFFSET, {2'h0, ph, 5'h03});
      dev_rd(CTRL_OFFSET);
      chk("overrun clr", 32'({2'h0, ph, 5'h01}), got);
      axi_wr(EVENT_ADDR, 32'h0000_0003);
    end
  endtask : t_host_master
  task automatic t_dev_master();
    logic [7:0] cw [4] = '{8'h81, 8'h8D, 8'hA3, 8'hC1};
    logic       ln [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
    int         hp [4] = '{8, 32, 8, 20};
    for (int i = 0; i < 4; i++) begin
      ph = cw[i][5];
      low_noise_mode <= ln[i];
      axi_wr(CFG_ADDR, {29'h0000_0000, ph, 2'h1});
      axi_wr(TX_ADDR, 32'h0000_0069 + 32'(i));
      dev_wr(CTRL_OFFSET, cw[i]);
      dev_wr(BUFFER_OFFSET, 8'h96 + 8'(i));
      frame();
      chk("half", 32'(hp[i]), 32'(half));
      chk("wire", 32'h0000_0069 + 32'(i), 32'(cap));
      dev_rd(BUFFER_OFFSET);
      chk("dev rx", 32'h0000_0069 + 32'(i), got);
      axi_rd(RX_ADDR, RESP_OKAY);
      chk("host rx", 32'h0000_0096 + 32'(i), got);
    end
    low_noise_mode <= 1'h0;
  endtask : t_dev_master
  task automatic t_wake();
    ph = 1'h0;
    dev_wr(COMPARE_OFFSET, 8'h5A);
    dev_wr(CTRL_OFFSET, 8'h0D);
    axi_wr(CFG_ADDR, 32'h0000_0703);
    asleep <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      axi_wr(TX_ADDR, 32'h0000_005A + 32'(i));
      frame();
      chk("wake", 32'h0000_0001, 32'(n_wake));
      axi_rd(RX_ADDR, RESP_OKAY);
      chk("port owns out", 32'h0000_0000, got);
    end
    asleep <= 1'h0;
  endtask : t_wake
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_host_master();
    t_dev_master();
    t_wake();
    complete_run();
  end
  initial begin
    #200_000;
    n_errors++;
    complete_run();
  end
endmodule : tb
